// ==== logic/vid_ctrl_map.svh ====
// Offsets, codes and timing counts for the serial VID phase shedding controller
`ifndef VID_CTRL_MAP_SVH
`define VID_CTRL_MAP_SVH

// Reference codes are in 12.5 mV steps above zero
`define VC_REF_W 8
`define VC_VID_ZERO_STEPS 8'h7C
`define VC_VID_OFF_FIRST 7'h7C
`define VC_FIX_1V4 8'h70
`define VC_FIX_1V2 8'h60
`define VC_FIX_1V0 8'h50
`define VC_FIX_0V8 8'h40
`define VC_START_1V1 8'h58
`define VC_START_1V0 8'h50
`define VC_START_0V9 8'h48
`define VC_START_0V8 8'h40

// Phase count kept in power saving
`define VC_KEEP_TWO 2'h0
`define VC_KEEP_THREE 2'h1
`define VC_KEEP_ONE 2'h2

// PWM cycles between shed or add steps
`define VC_DLY_ONE 2'h0
`define VC_DLY_ZERO 2'h1
`define VC_DLY_TWO 2'h2
`define VC_DLY_FOUR 2'h3

// Reference step interval during ramps
`define VC_STEP_TIME_NS 1000
`define VC_CLK_PERIOD_NS 10
`define VC_STEP_CYCLES (`VC_STEP_TIME_NS / `VC_CLK_PERIOD_NS)

`endif

// ==== logic/vid_ctrl_pkg.sv ====
// Types for the serial VID phase shedding controller
package vid_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SOFT = 2'b01,
    ST_RUN = 2'b10,
    ST_DOWN = 2'b11
  } seq_state_t;

  typedef logic [7:0] ref_code_t;
endpackage : vid_ctrl_pkg

// ==== logic/ref_stepper.sv ====
// One plane reference stepping one code per tick toward its target
`timescale 1ns/100ps
`default_nettype none
module ref_stepper (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire vid_ctrl_pkg::ref_code_t target,
  output vid_ctrl_pkg::ref_code_t level_q,
  output logic at_target
);
  import vid_ctrl_pkg::*;

  ref_code_t level_d;

  assign at_target = (level_q == target);

  always_comb begin
    level_d = level_q;
    if (tick && (level_q < target)) begin
      level_d = level_q + 8'h01;
    end else if (tick && (level_q > target)) begin
      level_d = level_q - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_q <= 8'h00;
    end else begin
      level_q <= level_d;
    end
  end
endmodule : ref_stepper
`default_nettype wire

// ==== logic/serial_vid_phase_shed_ctrl.sv ====
// Plane reference sequencing, power good and phase shedding for a dual-plane regulator
//
// Behaviour
// [RULE_01] Fixed select high: strap levels 00/01/10/11 give 1.4/1.2/1.0/0.8 V.
// [RULE_02] Fixed-mode select and strap changes are followed while running.
// [RULE_03] After enable both plane references step gradually up to target.
// [RULE_04] Power good rises only after soft-start ends and planes regulate.
// [RULE_05] Enable falling ramps both plane references down to near zero.
// [RULE_06] Processor raises platform power ok only after power good is high.
// [RULE_07] Set-voltage command steps each addressed plane to the decoded code.
// [RULE_08] Code zero is 1.55 V, minus 12.5 mV per count; top four codes off.
// [RULE_09] Core plane off by command keeps power good; bridge stays active.
// [RULE_10] Platform power ok low returns both planes to held start-up code.
// [RULE_11] Platform power ok back high holds targets until a new command.
// [RULE_12] Power good lost in running state steps both planes down to zero.
// [RULE_13] Command bit 7 hint: zero requests power saving, one normal.
// [RULE_14] Power saving keeps two phases by default, or three or one.
// [RULE_15] Phases shed one after another downward starting from channel 4.
// [RULE_16] A shed phase tri-states only at its next PWM rising instant.
// [RULE_17] Shed spacing is one PWM cycle by default, or zero, two, four.
// [RULE_18] Hint one reactivates shed phases from the lowest numbered one.
// [RULE_19] A reactivated phase leaves tri-state at its next PWM rising instant.
// [RULE_20] Reactivation spacing is one PWM cycle by default, or zero, two, four.
// [RULE_21] New voltage with hint zero in saving: exit, step, then re-enter.
// [RULE_22] Core offset stays in power saving unless its removal is selected.
// [RULE_23] Fixed select low: start-up levels 00/01/10/11 give 1.1/1.0/0.9/0.8 V.
// [RULE_24] Start-up code latched on enable rise is both planes' initial target.
// [RULE_25] Shed timing uses the channel 1 PWM rising strobe (pwm_rise[0]) as cycle boundaries.
`timescale 1ns/100ps
`default_nettype none
`include "vid_ctrl_map.svh"
module serial_vid_phase_shed_ctrl #(
  parameter int NUM_PHASES = 4,
  parameter int STEP_CYCLES = `VC_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic fixed_voltage_select,
  input wire logic serial_vid_clock,
  input wire logic serial_vid_data,
  input wire logic platform_power_ok,
  input wire logic planes_in_regulation,
  input wire logic cmd_valid,
  input wire logic cmd_core_sel,
  input wire logic cmd_bridge_sel,
  input wire logic [6:0] serial_vid_code,
  input wire logic low_power_state_hint,
  input wire logic [NUM_PHASES-1:0] pwm_rise,
  input wire logic [1:0] shed_keep_sel,
  input wire logic [1:0] shed_delay_sel,
  input wire logic signed [7:0] core_offset,
  input wire logic offset_off_in_saving,
  output vid_ctrl_pkg::ref_code_t core_ref_q,
  output vid_ctrl_pkg::ref_code_t bridge_ref_q,
  output logic core_off_q,
  output logic outputs_power_good_q,
  output logic power_saving_q,
  output logic [NUM_PHASES-1:0] phase_on_q
);
  import vid_ctrl_pkg::*;

  function automatic ref_code_t strap_map(input logic fixed, input logic [1:0] lv);
    ref_code_t r;
    r = `VC_START_0V8;
    if (fixed) begin
      if (lv == 2'h0) r = `VC_FIX_1V4; // RULE_01
      else if (lv == 2'h1) r = `VC_FIX_1V2;
      else if (lv == 2'h2) r = `VC_FIX_1V0;
      else r = `VC_FIX_0V8;
    end else begin
      if (lv == 2'h0) r = `VC_START_1V1; // RULE_23
      else if (lv == 2'h1) r = `VC_START_1V0;
      else if (lv == 2'h2) r = `VC_START_0V9;
      else r = `VC_START_0V8;
    end
    return r;
  endfunction : strap_map

  function automatic logic [NUM_PHASES-1:0] top_bit(input logic [NUM_PHASES-1:0] v);
    logic [NUM_PHASES-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_PHASES; i++) begin
      if (v[i]) r = NUM_PHASES'(1) << i;
    end
    return r;
  endfunction : top_bit

  // Pin synchronisers
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic en_prev_q;
  logic pok_prev_q;
  wire en_s = sync2_q[0];
  wire fix_s = sync2_q[1];
  wire [1:0] strap_s = sync2_q[3:2];
  wire pok_s = sync2_q[4];
  wire inreg_s = sync2_q[5];
  wire en_rise = en_s && !en_prev_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      en_prev_q <= 1'b0;
      pok_prev_q <= 1'b0;
    end else begin
      sync1_q <= {planes_in_regulation, platform_power_ok, serial_vid_clock,
                  serial_vid_data, fixed_voltage_select, enable};
      sync2_q <= sync1_q;
      en_prev_q <= en_s;
      pok_prev_q <= pok_s;
    end
  end

  // Ramp tick divider
  logic [15:0] div_q;
  wire tick = (div_q == 16'(STEP_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (rst || tick) div_q <= 16'h0000;
    else div_q <= div_q + 16'h0001;
  end

  // Sequencer state and targets
  seq_state_t state_q, state_d;
  ref_code_t hold_q;
  ref_code_t tgt_core_q, tgt_core_d;
  ref_code_t tgt_bridge_q, tgt_bridge_d;
  ref_code_t stash_core_q, stash_core_d;
  ref_code_t stash_bridge_q, stash_bridge_d;
  logic stash_core_off_q, stash_core_off_d;
  logic core_off_d;
  logic save_d;
  logic vid_wait_q, vid_wait_d;
  logic resave_q, resave_d;
  ref_code_t core_lvl;
  ref_code_t bridge_lvl;
  logic core_at;
  logic bridge_at;

  wire down_mode = (state_q == ST_DOWN) || (state_q == ST_IDLE);
  wire [7:0] stp_core = down_mode ? 8'h00 : (core_off_q ? 8'h00 : tgt_core_q);
  wire [7:0] stp_bridge = down_mode ? 8'h00 : tgt_bridge_q;
  wire cmd_off = (serial_vid_code >= `VC_VID_OFF_FIRST); // RULE_08
  wire [7:0] cmd_ref = cmd_off ? 8'h00 : (`VC_VID_ZERO_STEPS - {1'b0, serial_vid_code});
  wire cmd_ok = (state_q == ST_RUN) && !fix_s && pok_s && cmd_valid; // RULE_10
  wire [7:0] new_core = cmd_core_sel ? cmd_ref : tgt_core_q;
  wire [7:0] new_bridge = cmd_bridge_sel ? cmd_ref : tgt_bridge_q;
  wire new_core_off = cmd_core_sel ? cmd_off : core_off_q;
  wire changes = (new_core != tgt_core_q) || (new_bridge != tgt_bridge_q)
                 || (new_core_off != core_off_q);
  wire all_on = (phase_on_q == {NUM_PHASES{1'b1}});

  ref_stepper u_core (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .target(stp_core),
    .level_q(core_lvl),
    .at_target(core_at)
  );

  ref_stepper u_bridge (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .target(stp_bridge),
    .level_q(bridge_lvl),
    .at_target(bridge_at)
  );

  always_comb begin
    state_d = state_q;
    tgt_core_d = tgt_core_q;
    tgt_bridge_d = tgt_bridge_q;
    core_off_d = core_off_q;
    save_d = power_saving_q;
    vid_wait_d = vid_wait_q;
    resave_d = resave_q;
    stash_core_d = stash_core_q;
    stash_bridge_d = stash_bridge_q;
    stash_core_off_d = stash_core_off_q;
    case (state_q)
      ST_IDLE: begin
        if (en_rise) begin
          tgt_core_d = strap_map(fix_s, strap_s); // RULE_24
          tgt_bridge_d = strap_map(fix_s, strap_s);
          core_off_d = 1'b0;
          save_d = 1'b0;
          vid_wait_d = 1'b0;
          resave_d = 1'b0;
          state_d = ST_SOFT; // RULE_03
        end
      end
      ST_SOFT: begin
        if (!en_s) state_d = ST_DOWN; // RULE_05
        else if (core_at && bridge_at && inreg_s) state_d = ST_RUN; // RULE_04
      end
      ST_RUN: begin
        if (!en_s || !inreg_s) begin
          state_d = ST_DOWN; // RULE_12
        end else if (fix_s) begin
          tgt_core_d = strap_map(1'b1, strap_s); // RULE_02
          tgt_bridge_d = strap_map(1'b1, strap_s);
          core_off_d = 1'b0;
        end else if (!pok_s) begin
          if (pok_prev_q) begin // RULE_11
            tgt_core_d = hold_q; // RULE_10
            tgt_bridge_d = hold_q;
            core_off_d = 1'b0;
            vid_wait_d = 1'b0;
            resave_d = 1'b0;
          end
        end else if (cmd_ok) begin
          if (!low_power_state_hint && power_saving_q && changes) begin
            save_d = 1'b0; // RULE_21
            vid_wait_d = 1'b1;
            resave_d = 1'b0;
            stash_core_d = new_core;
            stash_bridge_d = new_bridge;
            stash_core_off_d = new_core_off;
          end else if (vid_wait_q) begin
            stash_core_d = new_core;
            stash_bridge_d = new_bridge;
            stash_core_off_d = new_core_off;
          end else begin
            tgt_core_d = new_core; // RULE_07
            tgt_bridge_d = new_bridge;
            core_off_d = new_core_off; // RULE_09
            save_d = !low_power_state_hint; // RULE_13
            resave_d = 1'b0;
          end
        end else if (vid_wait_q && all_on) begin
          tgt_core_d = stash_core_q; // RULE_21
          tgt_bridge_d = stash_bridge_q;
          core_off_d = stash_core_off_q;
          vid_wait_d = 1'b0;
          resave_d = 1'b1;
        end else if (resave_q && core_at && bridge_at) begin
          save_d = 1'b1; // RULE_21
          resave_d = 1'b0;
        end
      end
      ST_DOWN: begin
        save_d = 1'b0;
        vid_wait_d = 1'b0;
        resave_d = 1'b0;
        if (!en_s && core_at && bridge_at) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      hold_q <= 8'h00;
      tgt_core_q <= 8'h00;
      tgt_bridge_q <= 8'h00;
      core_off_q <= 1'b0;
      power_saving_q <= 1'b0;
      vid_wait_q <= 1'b0;
      resave_q <= 1'b0;
      stash_core_q <= 8'h00;
      stash_bridge_q <= 8'h00;
      stash_core_off_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (en_rise) hold_q <= strap_map(1'b0, strap_s); // RULE_24
      tgt_core_q <= tgt_core_d;
      tgt_bridge_q <= tgt_bridge_d;
      core_off_q <= core_off_d;
      power_saving_q <= save_d;
      vid_wait_q <= vid_wait_d;
      resave_q <= resave_d;
      stash_core_q <= stash_core_d;
      stash_bridge_q <= stash_bridge_d;
      stash_core_off_q <= stash_core_off_d;
    end
  end

  // Outputs with core offset
  wire offset_on = !(power_saving_q && offset_off_in_saving); // RULE_22
  wire signed [9:0] core_sum = $signed({2'b00, core_lvl})
                               + (offset_on ? 10'(core_offset) : 10'sh000);
  wire [7:0] core_out = (core_lvl == 8'h00) ? 8'h00
                        : (core_sum < 10'sh000) ? 8'h00
                        : (core_sum > 10'sh0FF) ? 8'hFF : core_sum[7:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core_ref_q <= 8'h00;
      bridge_ref_q <= 8'h00;
      outputs_power_good_q <= 1'b0;
    end else begin
      core_ref_q <= core_out;
      bridge_ref_q <= bridge_lvl;
      outputs_power_good_q <= (state_d == ST_RUN); // RULE_04 RULE_09
    end
  end

  // Phase shedding sequencer
  logic [NUM_PHASES-1:0] keep_mask;
  logic [2:0] dly_cycles;
  logic [2:0] wait_q;
  assign keep_mask = (shed_keep_sel == `VC_KEEP_THREE) ? NUM_PHASES'(7) // RULE_14
                   : (shed_keep_sel == `VC_KEEP_ONE) ? NUM_PHASES'(1) : NUM_PHASES'(3);
  assign dly_cycles = (shed_delay_sel == `VC_DLY_ZERO) ? 3'h0 // RULE_17 RULE_20
                    : (shed_delay_sel == `VC_DLY_TWO) ? 3'h2
                    : (shed_delay_sel == `VC_DLY_FOUR) ? 3'h4 : 3'h1;
  wire saving_eff = power_saving_q && (state_q == ST_RUN);
  wire [NUM_PHASES-1:0] want_mask = saving_eff ? keep_mask : {NUM_PHASES{1'b1}};
  wire [NUM_PHASES-1:0] sheddable = phase_on_q & ~want_mask;
  wire [NUM_PHASES-1:0] addable = ~phase_on_q & want_mask;
  wire [NUM_PHASES-1:0] hi_shed = top_bit(sheddable); // RULE_15
  wire [NUM_PHASES-1:0] lo_add = addable & (~addable + NUM_PHASES'(1)); // RULE_18
  wire no_dly = (dly_cycles == 3'h0);
  wire [NUM_PHASES-1:0] shed_go = (no_dly ? sheddable : (wait_q == 3'h0 ? hi_shed : '0))
                                  & pwm_rise; // RULE_16
  wire [NUM_PHASES-1:0] add_go = (no_dly ? addable : (wait_q == 3'h0 ? lo_add : '0))
                                 & pwm_rise; // RULE_19
  wire stepped = |(shed_go | add_go);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_on_q <= {NUM_PHASES{1'b1}};
      wait_q <= 3'h0;
    end else begin
      phase_on_q <= (phase_on_q & ~shed_go) | add_go;
      if (stepped) wait_q <= dly_cycles; // RULE_17 RULE_20
      else if (pwm_rise[0] && wait_q != 3'h0) wait_q <= wait_q - 3'h1; // RULE_25
    end
  end
endmodule : serial_vid_phase_shed_ctrl
`default_nettype wire

// ==== sim/cpu_vid_model.sv ====
// Processor side model: power ok handshake and set-voltage commands
`timescale 1ns/100ps
`default_nettype none
module cpu_vid_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic outputs_power_good_q,
  input wire logic ok_want,
  input wire logic req,
  input wire logic [9:0] req_word,
  output logic platform_power_ok,
  output logic cmd_valid,
  output logic cmd_core_sel,
  output logic cmd_bridge_sel,
  output logic [6:0] serial_vid_code,
  output logic low_power_state_hint
);
  logic [9:0] word_q;
  initial begin
    platform_power_ok = 1'b0;
    cmd_valid = 1'b0;
    word_q = 10'h000;
  end
  assign {low_power_state_hint, cmd_core_sel, cmd_bridge_sel, serial_vid_code} = word_q;
  // Power ok only once power good seen
  always @(posedge sys_clk) begin
    platform_power_ok <= !rst && ok_want && (platform_power_ok || outputs_power_good_q);
    cmd_valid <= !rst && req;
    word_q <= req ? req_word : ~word_q;
  end
endmodule : cpu_vid_model
`default_nettype wire

// ==== sim/vid_ctrl_asserts.sv ====
// Port checker for the phase shedding controller
`timescale 1ns/100ps
`default_nettype none
`include "vid_ctrl_map.svh"
module vid_ctrl_checker #(
  parameter int NUM_PHASES = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic planes_in_regulation,
  input wire logic platform_power_ok,
  input wire logic cmd_valid,
  input wire logic low_power_state_hint,
  input wire logic [NUM_PHASES-1:0] pwm_rise,
  input wire logic [1:0] shed_keep_sel,
  input wire logic [1:0] shed_delay_sel,
  input wire vid_ctrl_pkg::ref_code_t core_ref_q,
  input wire vid_ctrl_pkg::ref_code_t bridge_ref_q,
  input wire logic core_off_q,
  input wire logic outputs_power_good_q,
  input wire logic power_saving_q,
  input wire logic [NUM_PHASES-1:0] phase_on_q
);
  import vid_ctrl_pkg::*;
  logic [2:0] keep;
  assign keep = shed_keep_sel == `VC_KEEP_THREE ? 3'h3 :
    shed_keep_sel == `VC_KEEP_ONE ? 3'h1 : 3'h2;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  pg_needs_reg_a: assert property (
    $rose(outputs_power_good_q) |-> $past(planes_in_regulation, 3))
    else $error("power good rose without regulation");
  ref_step_a: assert property (
    $changed(bridge_ref_q) |-> (bridge_ref_q - $past(bridge_ref_q)) inside {8'h01, 8'hFF})
    else $error("bridge reference jumped");
  phase_strobe_a: assert property (
    ((phase_on_q ^ $past(phase_on_q)) & ~$past(pwm_rise)) == '0)
    else $error("phase changed without its strobe");
  phase_order_a: assert property (
    phase_on_q[0] && (shed_delay_sel == `VC_DLY_ZERO || (phase_on_q & (phase_on_q + 1'b1)) == '0))
    else $error("phase pattern out of order");
  one_step_a: assert property (
    shed_delay_sel != `VC_DLY_ZERO |-> $onehot0(phase_on_q ^ $past(phase_on_q)))
    else $error("several phases moved at once");
  keep_count_a: assert property (
    power_saving_q |-> $countones(phase_on_q) >= keep)
    else $error("too few phases in saving");
  core_off_pg_a: assert property (
    $rose(core_off_q) |-> outputs_power_good_q ##[1:600] core_ref_q == 8'h00)
    else $error("core off lost power good or stayed up");
  hint_normal_a: assert property (
    cmd_valid && low_power_state_hint && outputs_power_good_q && platform_power_ok
    |=> !power_saving_q)
    else $error("normal hint left saving on");
  cover property ($rose(power_saving_q));
  cover property ($fell(phase_on_q[NUM_PHASES-1]));
  cover property ($rose(core_off_q));
endmodule : vid_ctrl_checker
bind serial_vid_phase_shed_ctrl vid_ctrl_checker #(.NUM_PHASES(NUM_PHASES)) u_chk (
  .sys_clk, .rst, .planes_in_regulation, .platform_power_ok, .cmd_valid,
  .low_power_state_hint, .pwm_rise, .shed_keep_sel, .shed_delay_sel, .core_ref_q,
  .bridge_ref_q, .core_off_q, .outputs_power_good_q, .power_saving_q, .phase_on_q);
`default_nettype wire

// ==== sim/tb_serial_vid_phase_shed_ctrl.sv ====
// Self-checking bench for the plane sequencer and phase shedding controller
`timescale 1ns/100ps
`default_nettype none
`include "vid_ctrl_map.svh"
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("MISMATCH at %0t got %h expected %h", $time, a, b); \
  end \
end
module tb_serial_vid_phase_shed_ctrl;
  import vid_ctrl_pkg::*;
  logic sys_clk = 0, rst = 1, enable = 0, fixed_voltage_select = 0, serial_vid_clock = 0;
  logic serial_vid_data = 0, planes_in_regulation = 1, ok_want = 0, req = 0;
  logic offset_off_in_saving = 0, platform_power_ok, cmd_valid, cmd_core_sel, cmd_bridge_sel;
  logic low_power_state_hint, core_off_q, outputs_power_good_q, power_saving_q;
  logic [9:0] req_word = 10'h000;
  logic [6:0] serial_vid_code, c, b;
  logic [3:0] pwm_rise = 4'h0, phase_on_q;
  logic [2:0] pc = 3'h0;
  logic [1:0] shed_keep_sel = `VC_KEEP_TWO, shed_delay_sel = `VC_DLY_ONE;
  logic signed [7:0] core_offset = 8'sh00;
  ref_code_t core_ref_q, bridge_ref_q;
  ref_code_t smap[4] = '{8'h58, 8'h50, 8'h48, 8'h40};
  ref_code_t fmap[4] = '{8'h70, 8'h60, 8'h50, 8'h40};
  logic [1:0] ks[4] = '{`VC_KEEP_TWO, `VC_KEEP_THREE, `VC_KEEP_ONE, `VC_KEEP_ONE};
  logic [1:0] ds[4] = '{`VC_DLY_ONE, `VC_DLY_TWO, `VC_DLY_FOUR, `VC_DLY_ZERO};
  logic [3:0] fin[4] = '{4'h3, 4'h7, 4'h1, 4'h1};
  int dn[4] = '{1, 2, 4, 0};
  int fail_count = 0, compares = 0, s0 = 0, cyc = 0;
  logic [23:0] q_exp[$], q_msk[$];
  event take;
  wire [23:0] obs = {core_ref_q, bridge_ref_q, outputs_power_good_q, core_off_q,
    power_saving_q, 1'b0, phase_on_q};
  serial_vid_phase_shed_ctrl #(.STEP_CYCLES(2)) u_dut (.sys_clk, .rst, .enable,
    .fixed_voltage_select, .serial_vid_clock, .serial_vid_data, .platform_power_ok,
    .planes_in_regulation, .cmd_valid, .cmd_core_sel, .cmd_bridge_sel, .serial_vid_code,
    .low_power_state_hint, .pwm_rise, .shed_keep_sel, .shed_delay_sel, .core_offset,
    .offset_off_in_saving, .core_ref_q, .bridge_ref_q, .core_off_q, .outputs_power_good_q,
    .power_saving_q, .phase_on_q);
  cpu_vid_model u_cpu (.sys_clk, .rst, .outputs_power_good_q, .ok_want, .req, .req_word,
    .platform_power_ok, .cmd_valid, .cmd_core_sel, .cmd_bridge_sel, .serial_vid_code,
    .low_power_state_hint);
  initial forever #5 sys_clk = ~sys_clk;
  // Per-phase rising strobes, phase i at slot 2i of 8
  always @(negedge sys_clk) begin
    pc <= pc + 3'h1;
    pwm_rise <= pc[0] ? 4'h0 : 4'h1 << pc[2:1];
  end
  always @(posedge sys_clk) begin
    s0 <= s0 + int'(pwm_rise[0]);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end
  // Oldest note against the outputs
  always @(take) begin
    while (q_exp.size() > 0) begin
      `CHK(obs & q_msk[0], q_exp[0] & q_msk[0])
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end
  end
  task automatic note(input logic [23:0] e, input logic [23:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
    -> take;
  endtask : note
  task automatic settle(input logic [23:0] e, input logic [23:0] m);
    for (int t = 0; t < 2000 && (obs & m) !== (e & m); t++) @(negedge sys_clk);
    note(e, m);
  endtask : settle
  task automatic up(input logic f, input logic [1:0] s, input ref_code_t r);
    enable = 0;
    settle(24'h0, 24'hFFFF80);
    fixed_voltage_select = f;
    {serial_vid_clock, serial_vid_data} = s;
    repeat (6) @(negedge sys_clk);
    enable = 1;
    settle({r, r, 8'h80}, 24'hFFFF80);
  endtask : up
  task automatic send(input logic cs, input logic bs, input logic [6:0] v, input logic h);
    req_word = {h, cs, bs, v};
    req = 1;
    @(negedge sys_clk);
    req = 0;
    repeat (1) @(negedge sys_clk);
  endtask : send
  task automatic track(input logic [3:0] f, input int n);
    logic [3:0] last;
    int m;
    last = phase_on_q;
    m = -1;
    for (int t = 0; t < 3000 && phase_on_q !== f; t++) begin
      @(negedge sys_clk);
      if (phase_on_q !== last) begin
        if (m >= 0 && n > 0) `CHK(s0 - m, n)
        m = s0;
        last = phase_on_q;
      end
    end
    note({16'h0, 2'h0, f != 4'hF, 1'b0, f}, 24'h00002F);
  endtask : track
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(32'h8528));
    repeat (3) @(negedge sys_clk);
    rst = 0;
    for (int i = 0; i < 4; i++) up(1'b0, i[1:0], smap[i]);
    $display("start-up map test done");
    up(1'b1, 2'h3, fmap[3]);
    for (int i = 2; i >= 0; i--) begin
      {serial_vid_clock, serial_vid_data} = i[1:0];
      settle({fmap[i], fmap[i], 8'h80}, 24'hFFFF80);
    end
    up(1'b0, 2'h1, 8'h50);
    $display("fixed map test done");
    ok_want = 1;
    repeat (10) @(negedge sys_clk);
    for (int i = 0; i < 5; i++) begin
      c = i == 0 ? 7'h00 : i == 1 ? 7'h7B : 7'($urandom_range(0, 123));
      b = 7'($urandom_range(0, 123));
      send(1'b1, 1'b0, c, 1'b1);
      send(1'b0, 1'b1, b, 1'b1);
      settle({8'(124 - c), 8'(124 - b), 8'h80}, 24'hFFFF80);
    end
    send(1'b1, 1'b0, 7'h7C + 7'($urandom_range(0, 3)), 1'b1);
    settle({8'h00, 8'(124 - b), 8'hC0}, 24'hFFFFC0);
    send(1'b1, 1'b1, 7'h1C, 1'b1);
    settle({8'h60, 8'h60, 8'h80}, 24'hFFFFC0);
    $display("command test done");
    ok_want = 0;
    settle({8'h50, 8'h50, 8'h80}, 24'hFFFF80);
    send(1'b1, 1'b1, 7'h10, 1'b1);
    repeat (20) @(negedge sys_clk);
    note({8'h50, 8'h50, 8'h80}, 24'hFFFF80);
    ok_want = 1;
    repeat (60) @(negedge sys_clk);
    note({8'h50, 8'h50, 8'h80}, 24'hFFFF80);
    $display("power ok test done");
    for (int i = 0; i < 4; i++) begin
      shed_keep_sel = ks[i];
      shed_delay_sel = ds[i];
      send(1'b1, 1'b1, 7'h2C, 1'b0);
      track(fin[i], dn[i]);
      send(1'b1, 1'b1, 7'h2C, 1'b1);
      track(4'hF, dn[i]);
    end
    $display("shedding test done");
    shed_keep_sel = `VC_KEEP_TWO;
    shed_delay_sel = `VC_DLY_ONE;
    send(1'b1, 1'b1, 7'h2C, 1'b0);
    track(4'h3, 1);
    send(1'b1, 1'b1, 7'h20, 1'b0);
    settle({8'h50, 8'h50, 8'h0F}, 24'hFFFF2F);
    settle({8'h5C, 8'h5C, 8'hA0}, 24'hFFFFA0);
    track(4'h3, 1);
    core_offset = 8'sh04;
    settle({8'h60, 8'h5C, 8'hA0}, 24'hFFFFA0);
    offset_off_in_saving = 1;
    settle({8'h5C, 8'h5C, 8'hA0}, 24'hFFFFA0);
    send(1'b1, 1'b1, 7'h20, 1'b1);
    settle({8'h60, 8'h5C, 8'h80}, 24'hFFFFA0);
    $display("saving change test done");
    planes_in_regulation = 0;
    settle(24'h0, 24'hFFFF80);
    $display("power good loss test done");
    test_done();
  end
endmodule : tb_serial_vid_phase_shed_ctrl
`default_nettype wire
